// ---- hw/pdrds_top.sv ----
// register bank for power-down/reference control and output drive style
`timescale 1ns/1ps
`default_nettype none
`include "pdrds_cfg.svh"
module pdrds_top #(
   parameter int CHANNELS = 8
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire pdrds_pkg::pdrds_wr_t wr,
   input wire logic [7:0] is_dac,
   input wire logic [7:0] gpo_select,
   input wire logic [7:0] gpo_data,
   output logic [15:0] pd_rdata,
   output logic [15:0] ds_rdata,
   output pdrds_pkg::pdrds_pwr_t pwr,
   output logic vref_pin_en,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe
);
   // the bit map of both registers fixes eight channels; any other count cannot be served
   if (CHANNELS != 8) begin : g_bad_channels
      $error("pdrds_top supports exactly eight channels");
   end

   // stored register contents and their next values
   logic [15:0] pd_q;
   logic [15:0] pd_d;
   logic [15:0] ds_q;
   logic [15:0] ds_d;

   // next values of the registered outputs
   pdrds_pkg::pdrds_pwr_t pwr_d;
   logic [7:0] out_d;
   logic [7:0] oe_d;
   logic vref_d;

   // register writes; reserved bits masked so they never store
   always_comb begin
      pd_d = pd_q;
      ds_d = ds_q;
      if (wr.pd_we) begin
         pd_d = wr.wdata & `PDRDS_PD_MASK;
      end
      if (wr.ds_we) begin
         ds_d = wr.wdata & `PDRDS_DS_MASK;
      end
   end

   // power decisions; global power-down dominates everything
   always_comb begin
      pwr_d.adc_on = !pd_q[`PDRDS_BIT_GLOBAL_PD];
      pwr_d.ref_on = !pd_q[`PDRDS_BIT_GLOBAL_PD] && pd_q[`PDRDS_BIT_REF_EN];
      vref_d = pwr_d.ref_on;
      for (int i = 0; i < CHANNELS; i++) begin
         // sleep only counts for DAC-configured channels
         pwr_d.dac_on[i] = is_dac[i] && !pd_q[`PDRDS_BIT_GLOBAL_PD] && !pd_q[i];
      end
   end

   // pin drivers: open-drain only drives low, push/pull drives both levels
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         out_d[i] = gpo_data[i];
         if (!gpo_select[i]) begin
            oe_d[i] = 1'b0; // pin owned by other functions
         end else if (ds_q[i]) begin
            out_d[i] = 1'b0;
            oe_d[i] = !gpo_data[i];
         end else begin
            oe_d[i] = 1'b1;
         end
      end
   end

   // all state and outputs registered; reset gives zeros
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pd_q <= `PDRDS_PD_RESET;
         ds_q <= `PDRDS_DS_RESET;
         pwr <= '0;
         vref_pin_en <= 1'b0;
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
         pd_rdata <= 16'h0000;
         ds_rdata <= 16'h0000;
      end else begin
         pd_q <= pd_d;
         ds_q <= ds_d;
         pwr <= pwr_d;
         vref_pin_en <= vref_d;
         pin_out <= out_d;
         pin_oe <= oe_d;
         pd_rdata <= pd_q; // one cycle behind the register
         ds_rdata <= ds_q;
      end
   end

   chk_global_global_power_down: assert property (@(posedge clk_sys) disable iff (reset)
      $past(pd_q[10]) |-> (pwr.adc_on == 1'b0 && pwr.ref_on == 1'b0 && pwr.dac_on == 8'h00))
      else $error("global power-down not honoured");
   chk_ref_follow_en: assert property (@(posedge clk_sys) disable iff (reset)
      !$past(pd_q[10]) |-> (pwr.ref_on == $past(pd_q[9])))
      else $error("reference does not follow enable");
   chk_vref_pin_ref: assert property (@(posedge clk_sys) disable iff (reset)
      vref_pin_en == pwr.ref_on)
      else $error("reference pin mismatch");
   chk_dac_sleep_bit: assert property (@(posedge clk_sys) disable iff (reset)
      (!pd_q[10] && is_dac[0] && pd_q[0]) |=> !pwr.dac_on[0])
      else $error("dac0 sleep ignored");
   chk_pd_reset_zero: assert property (@(posedge clk_sys)
      $past(reset) |-> (pd_q == 16'h0000 && ds_q == 16'h0000))
      else $error("registers not zero after reset");
   chk_od_never_high: assert property (@(posedge clk_sys) disable iff (reset)
      ($past(ds_q[1]) && $past(gpo_select[1])) |-> !(pin_oe[1] && pin_out[1]))
      else $error("open-drain pin drove high");
   chk_pp_drives: assert property (@(posedge clk_sys) disable iff (reset)
      (!ds_q[2] && gpo_select[2]) |=> (pin_oe[2] && pin_out[2] == $past(gpo_data[2])))
      else $error("push/pull pin not driven");
   chk_unsel_no_drive: assert property (@(posedge clk_sys) disable iff (reset)
      !gpo_select[3] |=> !pin_oe[3])
      else $error("unselected pin driven");
   chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
      pd_rdata[15:11] == 5'h00 && ds_rdata[15:8] == 8'h00)
      else $error("reserved bits read nonzero");
   cov_global_pd: cover property (@(posedge clk_sys) disable iff (reset) pd_q[10]);
   cov_ref_on: cover property (@(posedge clk_sys) disable iff (reset) pwr.ref_on);
   cov_open_drain: cover property (@(posedge clk_sys) disable iff (reset) ds_q[0] && gpo_select[0]);
   cov_dac_sleep: cover property (@(posedge clk_sys) disable iff (reset) is_dac[1] && pd_q[1] && !pd_q[10]);
   cov_push_pull: cover property (@(posedge clk_sys) disable iff (reset) !ds_q[4] && gpo_select[4]);

   // outputs still show the reset zeros at the first edge after release,
   // so the checks below that expect a powered state skip that one edge

   // the ADC has no enable of its own; only the global bit gates it
   chk_adc_global_only: assert property (@(posedge clk_sys) disable iff (reset)
      !$past(reset) |-> (pwr.adc_on == !$past(pd_q[10])))
      else $error("adc power does not follow global bit");

   // a cleared enable must keep reference and its pin off
   chk_ref_off_disabled: assert property (@(posedge clk_sys) disable iff (reset)
      !$past(pd_q[9]) |-> (!pwr.ref_on && !vref_pin_en))
      else $error("reference powered while disabled");

   // a set enable without global power-down brings reference and pin up
   chk_ref_on_enabled: assert property (@(posedge clk_sys) disable iff (reset)
      (!$past(reset) && $past(pd_q[9]) && !$past(pd_q[10])) |-> (pwr.ref_on && vref_pin_en))
      else $error("reference not powered while enabled");

   // a power-down write stores its data with the reserved bits cleared
   chk_pd_write_lands: assert property (@(posedge clk_sys) disable iff (reset)
      wr.pd_we |=> (pd_q == ($past(wr.wdata) & `PDRDS_PD_MASK)))
      else $error("power-down write not stored");

   // a drive-style write stores its data with the reserved bits cleared
   chk_ds_write_lands: assert property (@(posedge clk_sys) disable iff (reset)
      wr.ds_we |=> (ds_q == ($past(wr.wdata) & `PDRDS_DS_MASK)))
      else $error("drive-style write not stored");

   // reserved positions never hold a one in either stored register
   chk_reserved_store: assert property (@(posedge clk_sys) disable iff (reset)
      pd_q[15:11] == 5'h00 && ds_q[15:8] == 8'h00)
      else $error("reserved bits stored nonzero");

   // readback trails the register by exactly one edge
   chk_readback_lag: assert property (@(posedge clk_sys) disable iff (reset)
      !$past(reset) |-> (pd_rdata == $past(pd_q) && ds_rdata == $past(ds_q)))
      else $error("readback does not trail register");

   // per-channel checks; the channel 0 to 3 checks above are kept as quick smoke checks
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan_chk

      // a slept channel is never powered
      chk_dac_sleep_chan: assert property (@(posedge clk_sys) disable iff (reset)
         $past(pd_q[ch]) |-> !pwr.dac_on[ch])
         else $error("slept dac channel powered");

      // an awake DAC channel is powered when the global bit is clear
      chk_dac_awake_chan: assert property (@(posedge clk_sys) disable iff (reset)
         (!$past(reset) && $past(is_dac[ch]) && !$past(pd_q[10]) && !$past(pd_q[ch])) |-> pwr.dac_on[ch])
         else $error("awake dac channel not powered");

      // a channel used for something else reports no DAC power
      chk_non_dac_off: assert property (@(posedge clk_sys) disable iff (reset)
         !$past(is_dac[ch]) |-> !pwr.dac_on[ch])
         else $error("non-dac channel reports power");

      // open-drain pulls low when the data is low
      chk_od_pull_low: assert property (@(posedge clk_sys) disable iff (reset)
         (!$past(reset) && $past(gpo_select[ch]) && $past(ds_q[ch]) && !$past(gpo_data[ch]))
         |-> (pin_oe[ch] && !pin_out[ch]))
         else $error("open-drain pin not pulled low");

      // open-drain releases the pin when the data is high
      chk_od_release: assert property (@(posedge clk_sys) disable iff (reset)
         ($past(gpo_select[ch]) && $past(ds_q[ch]) && $past(gpo_data[ch])) |-> !pin_oe[ch])
         else $error("open-drain pin not released");

      // push/pull drives the data level on a selected pin
      chk_pp_level: assert property (@(posedge clk_sys) disable iff (reset)
         (!$past(reset) && $past(gpo_select[ch]) && !$past(ds_q[ch]))
         |-> (pin_oe[ch] && pin_out[ch] == $past(gpo_data[ch])))
         else $error("push/pull pin level wrong");

      // drive style is ignored on pins that are not outputs
      chk_unsel_release: assert property (@(posedge clk_sys) disable iff (reset)
         !$past(gpo_select[ch]) |-> !pin_oe[ch])
         else $error("unselected pin driven");
   end
endmodule : pdrds_top
`default_nettype wire

// ---- hw/pdrds_cfg.svh ----
// constants for the power-down/reference and drive-style register bank
`ifndef PDRDS_CFG_SVH
`define PDRDS_CFG_SVH
`define PDRDS_PD_RESET 16'h0000
`define PDRDS_DS_RESET 16'h0000
`define PDRDS_PD_MASK 16'h07FF
`define PDRDS_DS_MASK 16'h00FF
`define PDRDS_BIT_GLOBAL_PD 10
`define PDRDS_BIT_REF_EN 9
`endif

// ---- hw/pdrds_pkg.sv ----
// types for the power-down/reference and drive-style register bank
package pdrds_pkg;
   // register write port bundle coming from the serial-link decoder
   typedef struct packed {
      logic pd_we;
      logic ds_we;
      logic [15:0] wdata;
   } pdrds_wr_t;
   // analog power controls
   typedef struct packed {
      logic adc_on;
      logic ref_on;
      logic [7:0] dac_on;
   } pdrds_pwr_t;
endpackage : pdrds_pkg

// ---- bench/pdrds_host.sv ----
// host model that issues register write strobes
`timescale 1ns/1ps
`default_nettype none
module pdrds_host #(parameter bit EXT_REF = 1'b0) (
   input wire logic clk_sys,
   output pdrds_pkg::pdrds_wr_t wr
);
   initial wr = '0;
   // one-cycle strobe; bit 9 held low when an external reference is fitted
   task automatic put(input logic pd, input logic ds, input logic [15:0] d);
      wr <= {pd, ds, d & ~(EXT_REF ? 16'h0200 : 16'h0000)};
      @(posedge clk_sys);
      wr <= '0;
   endtask : put
endmodule : pdrds_host
`default_nettype wire

// ---- bench/pdrds_top_tb_top.sv ----
// self-checking bench for the power and drive-style register bank
`timescale 1ns/1ps
`default_nettype none
module pdrds_top_tb_top;
   logic clk_sys, reset, vref_pin_en;
   logic [7:0] is_dac, gpo_select, gpo_data, pin_out, pin_oe;
   logic [15:0] pd_rdata, ds_rdata, pd_e, ds_e, d;
   logic [1:0] s;
   pdrds_pkg::pdrds_wr_t wr;
   pdrds_pkg::pdrds_pwr_t pwr;
   logic [58:0] q[$];
   int errors = 0, n_checks = 0, seed = 15, cycles = 0;
   pdrds_host host (.clk_sys(clk_sys), .wr(wr));
   pdrds_top uut (.clk_sys(clk_sys), .reset(reset), .wr(wr), .is_dac(is_dac), .gpo_select(gpo_select),
      .gpo_data(gpo_data), .pd_rdata(pd_rdata), .ds_rdata(ds_rdata), .pwr(pwr),
      .vref_pin_en(vref_pin_en), .pin_out(pin_out), .pin_oe(pin_oe));
   initial begin
      clk_sys = 0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic end_of_test;
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic compare(input logic [58:0] e, input logic [58:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : compare
   // expected outputs; open-drain pins never drive high, only release
   function automatic logic [58:0] exp_w();
      logic on;
      on = !pd_e[10];
      return {pd_e, ds_e, on, on & pd_e[9], {8{on}} & is_dac & ~pd_e[7:0], on & pd_e[9],
         gpo_select & ~ds_e[7:0] & gpo_data, gpo_select & ~(ds_e[7:0] & gpo_data)};
   endfunction : exp_w
   // monitor: outputs are settled by the falling edge; also guards against a hang
   always @(negedge clk_sys) begin
      cycles++;
      if (cycles > 3000) begin
         errors++;
         end_of_test();
      end
      while (q.size() > 0) compare(q.pop_front(), {pd_rdata, ds_rdata, pwr, vref_pin_en,
         pin_out & gpo_select, pin_oe});
   end
   // random writes, neither, either or both strobes, with random pin and channel setup
   initial begin
      reset = 1;
      is_dac = 0;
      gpo_select = 0;
      gpo_data = 0;
      pd_e = 0;
      ds_e = 0;
      repeat (2) @(posedge clk_sys);
      reset <= 0;
      @(posedge clk_sys);
      #1 q.push_back(exp_w());
      repeat (300) begin
         @(posedge clk_sys);
         s = $random(seed);
         d = $random(seed);
         is_dac <= $random(seed);
         gpo_select <= $random(seed);
         gpo_data <= $random(seed);
         host.put(s[1], s[0], d);
         if (s[1]) pd_e = d & 16'h07ff;
         if (s[0]) ds_e = d & 16'h00ff;
         @(posedge clk_sys);
         #1 q.push_back(exp_w());
      end
      @(posedge clk_sys);
      end_of_test();
   end
endmodule : pdrds_top_tb_top
`default_nettype wire
